// ===== rtl/sfspi_front.sv
// Serial front end: framing, shifting, pause, protect and busy report
`timescale 1ns/1ns
`include "sfspi_cfg.svh"
module sfspi_front #(
  parameter int SYNC_STAGES = 3       // Pin synchroniser depth
) (
  input  wire logic       core_clk,        // System clock, 100 MHz
  input  wire logic       sys_rst,         // Async reset, active high
  input  wire logic       clk_en,          // Freezes all state when low
  input  wire logic       sel_n,           // Chip select pin, active low
  input  wire logic       sclk,            // Serial clock pin
  input  wire logic       sdi,             // Serial data in pin
  input  wire logic       pause_n,         // Pause pin, active low
  input  wire logic       wp_n,            // Write-protect pin, active low
  input  wire logic       write_busy,      // Internal write running
  input  wire logic       auto_increment_program, // Auto-increment mode
  input  wire logic       rdy_out_en,      // Ready/busy on output enabled
  input  wire logic       lock_bit_in,     // Protection lock bit value
  input  wire logic [7:0] tx_byte,         // Next byte to shift out
  output logic            sdo_o,           // Serial data out level
  output logic            sdo_oe_n,        // Output enable, low = drive
  output logic [7:0]      rx_byte,         // Last received byte
  output logic            rx_valid,        // Pulse: byte received
  output logic            rx_first,        // Byte was command byte
  output logic            tx_load,         // Pulse: tx_byte consumed
  output logic            paused,          // Pause state active
  output logic            lock_active,     // Lock bit blocks status write
  output logic [7:0]      status_byte      // Status image, busy in bit 0
);
  // Only the three-stage filter is built; refuse any other depth
  if (SYNC_STAGES != 3) begin : g_stage_chk
    $error("SYNC_STAGES must be 3");
  end

  // Three-flop synchronisers; stage 1 only feeds stage 2
  logic [2:0] cs_q, ck_q, di_q, hd_q, wp_q;
  logic [2:0] cs_d, ck_d, di_d, hd_d, wp_d;
  logic cs_s_q, ck_s_q, hd_s_q, wp_s_q, cs_s_d, ck_s_d, hd_s_d, wp_s_d;

  always_comb begin
    cs_d = {cs_q[1:0], sel_n};
    ck_d = {ck_q[1:0], sclk};
    di_d = {di_q[1:0], sdi};
    hd_d = {hd_q[1:0], pause_n};
    wp_d = {wp_q[1:0], wp_n};
    // A change counts once stages two and three agree
    cs_s_d = (cs_q[1] == cs_q[2]) ? cs_q[2] : cs_s_q;
    ck_s_d = (ck_q[1] == ck_q[2]) ? ck_q[2] : ck_s_q;
    hd_s_d = (hd_q[1] == hd_q[2]) ? hd_q[2] : hd_s_q;
    wp_s_d = (wp_q[1] == wp_q[2]) ? wp_q[2] : wp_s_q;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cs_q <= 3'h7;
      ck_q <= 3'h0;
      di_q <= 3'h0;
      hd_q <= 3'h7;
      wp_q <= 3'h7;
      cs_s_q <= 1'b1;
      ck_s_q <= 1'b0;
      hd_s_q <= 1'b1;
      wp_s_q <= 1'b1;
    end else if (clk_en) begin
      cs_q <= cs_d;
      ck_q <= ck_d;
      di_q <= di_d;
      hd_q <= hd_d;
      wp_q <= wp_d;
      cs_s_q <= cs_s_d;
      ck_s_q <= ck_s_d;
      hd_s_q <= hd_s_d;
      wp_s_q <= wp_s_d;
    end
  end

  // Edge events on the filtered levels
  logic ck_rise, ck_fall, cs_fall, cs_rise;
  assign ck_rise = ck_s_d & ~ck_s_q;
  assign ck_fall = ~ck_s_d & ck_s_q;
  assign cs_fall = ~cs_s_d & cs_s_q;
  assign cs_rise = cs_s_d & ~cs_s_q;

  // Framing and shift state
  sfspi_pkg::sfspi_state_t st_q, st_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d, tx_q, tx_d, rx_q, rx_d;
  logic       first_q, first_d, rxv_q, rxv_d, rxf_q, rxf_d;
  logic       ld_q, ld_d, sdo_q, sdo_d, oe_n_q, oe_n_d;
  logic       pend_q, pend_d, lk_q, lk_d;
  logic [7:0] stat_q, stat_d;

  // Ready/busy mode takes over the output line
  logic ry_mode;
  assign ry_mode = auto_increment_program & rdy_out_en;

  // Level for the output line at bit position idx, MSB first
  function automatic logic out_bit(input logic       ry,
                                   input logic       busy,
                                   input logic [7:0] data,
                                   input logic [2:0] idx);
    logic b;
    if (ry) begin
      b = ~busy; // High means ready
    end else begin
      b = data[3'h7 - idx];
    end
    return b;
  endfunction : out_bit

  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    sh_d = sh_q;
    tx_d = tx_q;
    rx_d = rx_q;
    first_d = first_q;
    rxv_d = 1'b0;
    rxf_d = rxf_q;
    ld_d = 1'b0;
    sdo_d = sdo_q;
    oe_n_d = oe_n_q;
    pend_d = pend_q;
    case (st_q)
      sfspi_pkg::SFSPI_IDLE: begin
        oe_n_d = 1'b1;
        if (cs_fall) begin
          st_d = sfspi_pkg::SFSPI_ACTIVE;
          bit_d = 3'h0;
          first_d = 1'b1;
          tx_d = tx_byte;
          ld_d = 1'b1;
          // Clock idling low: no fall comes before the first rise, so
          // the MSB goes out at select already
          sdo_d = out_bit(ry_mode, write_busy, tx_byte, 3'h0);
          oe_n_d = ck_s_q;
        end
      end
      sfspi_pkg::SFSPI_ACTIVE: begin
        if (cs_rise) begin // partial bits dropped
          st_d = sfspi_pkg::SFSPI_IDLE;
          oe_n_d = 1'b1;
        end else if (!hd_s_q && !ck_s_q) begin
          st_d = sfspi_pkg::SFSPI_PAUSED;
          oe_n_d = 1'b1;
        end else begin
          // Both idle levels work: only edges inside select count
          if (ck_rise) begin
            sh_d = {sh_q[6:0], di_q[2]};
            bit_d = bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              rx_d = {sh_q[6:0], di_q[2]};
              rxv_d = 1'b1;
              rxf_d = first_q;
              first_d = 1'b0;
            end
          end
          if (ck_fall) begin
            oe_n_d = 1'b0;
            if (bit_q == 3'h0 && !first_q && !ry_mode) begin
              // Byte boundary: the new byte's MSB leaves, not the old one
              sdo_d = out_bit(ry_mode, write_busy, tx_byte, 3'h0);
              tx_d = tx_byte;
              ld_d = 1'b1;
            end else begin
              sdo_d = out_bit(ry_mode, write_busy, tx_q, bit_q);
            end
          end
        end
      end
      sfspi_pkg::SFSPI_PAUSED: begin
        oe_n_d = 1'b1; // sclk and sdi ignored here
        if (cs_rise) begin
          st_d = sfspi_pkg::SFSPI_IDLE;
        end else if (hd_s_q && !ck_s_q) begin
          st_d = sfspi_pkg::SFSPI_ACTIVE; // position kept
          oe_n_d = ~pend_q;
        end
      end
      default: st_d = sfspi_pkg::SFSPI_IDLE;
    endcase
    // Drive state as it stood before pause entry, so release restores it
    if (st_q == sfspi_pkg::SFSPI_ACTIVE) begin
      pend_d = ~oe_n_q;
    end
    // Lock bit only bites while write-protect is low
    lk_d = lock_bit_in & ~wp_s_q;
    stat_d = 8'h00;
    stat_d[`SFSPI_BUSY_BIT] = write_busy;
    stat_d[`SFSPI_AAI_BIT] = auto_increment_program;
    stat_d[`SFSPI_LOCK_BIT] = lock_bit_in;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= sfspi_pkg::SFSPI_IDLE;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      rx_q <= 8'h00;
      first_q <= 1'b0;
      rxv_q <= 1'b0;
      rxf_q <= 1'b0;
      ld_q <= 1'b0;
      sdo_q <= 1'b0;
      oe_n_q <= 1'b1;
      pend_q <= 1'b0;
      lk_q <= 1'b0;
      stat_q <= 8'h00;
    end else if (clk_en) begin
      st_q <= st_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      rx_q <= rx_d;
      first_q <= first_d;
      rxv_q <= rxv_d;
      rxf_q <= rxf_d;
      ld_q <= ld_d;
      sdo_q <= sdo_d;
      oe_n_q <= oe_n_d;
      pend_q <= pend_d;
      lk_q <= lk_d;
      stat_q <= stat_d;
    end
  end

  // Paused flag registered alongside state
  logic pz_q;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) pz_q <= 1'b0;
    else if (clk_en) pz_q <= (st_d == sfspi_pkg::SFSPI_PAUSED);
  end

  assign sdo_o = sdo_q;
  assign sdo_oe_n = oe_n_q;
  assign rx_byte = rx_q;
  assign rx_valid = rxv_q;
  assign rx_first = rxf_q;
  assign tx_load = ld_q;
  assign paused = pz_q;
  assign lock_active = lk_q;
  assign status_byte = stat_q;
endmodule : sfspi_front

// ===== rtl/sfspi_cfg.svh
// Constants of the serial flash front end
// What this block does
// - A new command starts only after chip select falls.
// - Input bits are sampled at each rising serial clock edge.
// - The output line changes after each falling serial clock edge.
// - In auto-increment programming the output line may show ready/busy.
// - A low pause input freezes the transfer without losing its place.
// - The write-protect pin enables the lock effect of the lock bit.
// - The link works with the clock idling low (mode 0) or high (mode 3).
// - A busy status bit reports a running program or erase.
// - Pause entry and release take effect only while the clock is low.
// - While paused the output floats and clock and input are ignored.
// - Chip select rising during pause resets the serial logic.
// - The busy bit is status bit 0, 1 while a write runs.
`ifndef SFSPI_CFG_SVH
`define SFSPI_CFG_SVH
`define SFSPI_BYTE_W    4'h8
`define SFSPI_BUSY_BIT  3'h0
`define SFSPI_WEL_BIT   3'h1
`define SFSPI_AAI_BIT   3'h6
`define SFSPI_LOCK_BIT  3'h7
`define SFSPI_PROT_RST  4'h7
`endif

// ===== rtl/sfspi_pkg.sv
// Types of the serial flash front end
package sfspi_pkg;
  typedef enum logic [1:0] {SFSPI_IDLE, SFSPI_ACTIVE, SFSPI_PAUSED}
    sfspi_state_t;
endpackage : sfspi_pkg

// ===== testbench/sfspi_front_asserts.sv
// Port checker of the serial flash front end
`timescale 1ns/1ns
module sfspi_front_asserts (
  input wire logic       core_clk,    // Clock
  input wire logic       sys_rst,     // Reset
  input wire logic       clk_en,      // Run enable
  input wire logic       sel_n,       // Chip select
  input wire logic       wp_n,        // Protect pin
  input wire logic       write_busy,  // Write running
  input wire logic       lock_bit_in, // Lock bit
  input wire logic       paused,      // Pause state
  input wire logic       sdo_oe_n,    // Output enable
  input wire logic       rx_valid,    // Byte pulse
  input wire logic       lock_active, // Lock effect
  input wire logic [7:0] status_byte  // Status image
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Six cycles cover the pin synchroniser
  property p_lk1; (clk_en && lock_bit_in && !wp_n)[*6] |-> lock_active;
  endproperty
  a_lk1: assert property (p_lk1) else $error("lock not active");
  property p_lk0; (clk_en && !(lock_bit_in && !wp_n))[*6] |-> !lock_active;
  endproperty
  a_lk0: assert property (p_lk0) else $error("lock stuck");
  property p_b1; (clk_en && write_busy)[*2] |-> status_byte[0]; endproperty
  a_b1: assert property (p_b1) else $error("busy bit low");
  property p_b0; (clk_en && !write_busy)[*2] |-> !status_byte[0];
  endproperty
  a_b0: assert property (p_b0) else $error("busy bit high");
  property p_fl; paused |-> sdo_oe_n; endproperty
  a_fl: assert property (p_fl) else $error("output driven paused");
  property p_ds; sel_n[*8] |-> !paused && sdo_oe_n; endproperty
  a_ds: assert property (p_ds) else $error("deselect not reset");
  property p_dr; sel_n[*8] |-> !rx_valid; endproperty
  a_dr: assert property (p_dr) else $error("byte while idle");
  property p_pl; rx_valid |=> !rx_valid; endproperty
  a_pl: assert property (p_pl) else $error("byte pulse long");
endmodule : sfspi_front_asserts
bind sfspi_front sfspi_front_asserts chk_u (.core_clk, .sys_rst, .clk_en,
  .sel_n, .wp_n, .write_busy, .lock_bit_in, .paused, .sdo_oe_n, .rx_valid,
  .lock_active, .status_byte);

// ===== testbench/sfspi_host.sv
// Bus host model: chip select, serial clock and data in
`timescale 1ns/1ns
module sfspi_host (
  input  wire logic core_clk,  // System clock
  input  wire logic sdo_o,     // Device output level
  input  wire logic sdo_oe_n,  // Device output enable, low = drive
  output logic      sel_n,     // Chip select
  output logic      sclk,      // Serial clock
  output logic      sdi        // Serial data in
);
  logic cpol = 1'b0; // Idle clock level, high for mode 3
  // Bus idles deselected with the clock low
  initial begin
    sel_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  // Half of the 80 ns link period
  task automatic half();
    repeat (4) @(negedge core_clk);
  endtask : half
  // Select stays low over whole sequences; released data line toggles
  task automatic sel(input logic v);
    half();
    sel_n = v;
    if (v) begin
      sclk = cpol;
      sdi = ~sdi;
    end
    half();
    half();
  endtask : sel
  // Bits MSB first; sampled late in the high half, device lags its pins
  task automatic xfer(input logic [7:0] tx, input int n,
                      output logic [7:0] rx);
    for (int i = 7; i > 7 - n; i--) begin
      sclk = 1'b0;
      sdi = tx[i];
      half();
      sclk = 1'b1;
      half();
      // A floating line reads as the inverse of the last level
      rx = {rx[6:0], sdo_oe_n ? ~sdo_o : sdo_o};
    end
  endtask : xfer
endmodule : sfspi_host

// ===== testbench/sfspi_front_test.sv
// Bench of the serial flash front end
`timescale 1ns/1ns
module sfspi_front_test;
  logic core_clk, sys_rst, clk_en, pause_n, wp_n, busy, aip;
  logic rdy, lock, sel_n, sclk, sdi, sdo_o, sdo_oe_n;
  logic rx_valid, rx_first, tx_load, paused, lock_active;
  logic [7:0] tx_byte, rx_byte, status_byte, r;
  int error_cnt = 0, check_count = 0, rx_cnt = 0, ld_cnt = 0;
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) if (rx_valid === 1'b1) rx_cnt <= rx_cnt + 1;
  always @(posedge core_clk) if (tx_load === 1'b1) ld_cnt <= ld_cnt + 1;
  sfspi_host host_u (.core_clk, .sdo_o, .sdo_oe_n, .sel_n, .sclk, .sdi);
  sfspi_front dut_u (.core_clk, .sys_rst, .clk_en, .sel_n, .sclk, .sdi,
    .pause_n, .wp_n, .write_busy(busy), .auto_increment_program(aip),
    .rdy_out_en(rdy), .lock_bit_in(lock), .tx_byte, .sdo_o, .sdo_oe_n,
    .rx_byte, .rx_valid, .rx_first, .tx_load, .paused, .lock_active,
    .status_byte);
  task automatic w(input int n);
    repeat (n) @(negedge core_clk);
  endtask : w
  task automatic chk(input string s, input logic [7:0] e, g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask : chk
  // Two bytes in mode 3, then one in mode 0
  task automatic t_frame();
    host_u.cpol = 1'b1;
    host_u.sel(1'b1);
    host_u.sel(1'b0);
    tx_byte = 8'h96;
    host_u.xfer(8'h9b, 8, r);
    w(6);
    chk("rx", 8'h9b, rx_byte);
    chk("first", 8'h01, {7'h0, rx_first});
    chk("out", 8'h3c, r);
    host_u.xfer(8'h41, 8, r);
    w(6);
    chk("rx2", 8'h41, rx_byte);
    chk("out2", 8'h96, r);
    chk("first2", 8'h00, {7'h0, rx_first});
    chk("load", 8'h02, ld_cnt[7:0]);
    host_u.sel(1'b1);
    host_u.cpol = 1'b0;
    host_u.sel(1'b1);
    host_u.sel(1'b0);
    host_u.xfer(8'hc6, 8, r);
    w(6);
    chk("mode0", 8'hc6, rx_byte);
    chk("mode0out", 8'h96, r);
    host_u.sel(1'b1);
    $display("t_frame done");
  endtask : t_frame
  // Partial byte dropped at deselect
  task automatic t_partial();
    int n;
    host_u.sel(1'b0);
    host_u.xfer(8'hff, 5, r);
    n = rx_cnt;
    host_u.sel(1'b1);
    chk("drop", n[7:0], rx_cnt[7:0]);
    host_u.sel(1'b0);
    host_u.xfer(8'h5a, 8, r);
    w(6);
    chk("fresh", 8'h5a, rx_byte);
    host_u.sel(1'b1);
    $display("t_partial done");
  endtask : t_partial
  // Pause mid-byte, entry and release wait for a low clock
  task automatic t_pause();
    host_u.sel(1'b0);
    host_u.xfer(8'ha0, 4, r);
    pause_n = 1'b0;
    w(8);
    chk("defer", 8'h00, {7'h0, paused});
    host_u.sclk = 1'b0;
    w(8);
    chk("hold", 8'h03, {6'h0, paused, sdo_oe_n});
    host_u.xfer(8'hff, 3, r);
    pause_n = 1'b1;
    w(8);
    chk("stay", 8'h01, {7'h0, paused});
    host_u.xfer(8'h30, 4, r);
    w(6);
    chk("resume", 8'ha3, rx_byte);
    // Deselect while paused mid-byte, then a fresh byte must land
    host_u.xfer(8'hff, 2, r);
    pause_n = 1'b0;
    host_u.sclk = 1'b0;
    w(8);
    chk("repause", 8'h01, {7'h0, paused});
    host_u.sel(1'b1);
    chk("desel", 8'h00, {7'h0, paused});
    pause_n = 1'b1;
    host_u.sel(1'b0);
    host_u.xfer(8'h69, 8, r);
    w(6);
    chk("after", 8'h69, rx_byte);
    host_u.sel(1'b1);
    $display("t_pause done");
  endtask : t_pause
  // Protect pin, status image, freeze and ready/busy output
  task automatic t_status();
    for (int i = 0; i < 4; i++) begin
      {lock, wp_n} = i[1:0];
      w(8);
      chk("lock", {7'h0, i == 2}, {7'h0, lock_active});
    end
    {busy, aip, rdy} = 3'h7;
    w(4);
    chk("status", 8'hc1, status_byte);
    clk_en = 1'b0;
    busy = 1'b0;
    w(4);
    chk("freeze", 8'hc1, status_byte);
    clk_en = 1'b1;
    w(4);
    chk("ready", 8'hc0, status_byte);
    busy = 1'b1;
    host_u.sel(1'b0);
    host_u.xfer(8'h00, 8, r);
    chk("rdyout", 8'h00, r);
    busy = 1'b0;
    host_u.xfer(8'h00, 8, r);
    chk("rdyout1", 8'hff, r);
    host_u.sel(1'b1);
    $display("t_status done");
  endtask : t_status
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  initial begin
    // Pins start idle; reset is held for ten clocks
    core_clk = 1'b0;
    sys_rst = 1'b1;
    {clk_en, pause_n, wp_n} = 3'h7;
    {busy, aip, rdy, lock} = 4'h0;
    tx_byte = 8'h3c;
    w(10);
    sys_rst = 1'b0;
    w(4);
    chk("oe", 8'h01, {7'h0, sdo_oe_n});
    t_frame();
    t_partial();
    t_pause();
    t_status();
    give_verdict();
  end
endmodule : sfspi_front_test
